// File: design/dmac_top.sv
/*
 * Multiply element and multiply-accumulate element of a signal-processing
 * slice. Operands come from fabric logic on mclk; configuration is static.
 */
// Functional notes
// - A per-cycle control selects signed or unsigned operands.
// - A per-cycle control makes the accumulator add or subtract.
// - Operands load in parallel or serially, switchable at run time.
// - The multiply element outputs A times B with no accumulation.
// - Multiply input, pipeline and output registers are each optional.
// - The accumulate element adds the product to its previous total.
// - Accumulate input/pipeline registers optional, output always there.
// - The accumulator can be loaded with a start value at run time.
// - Overflow comes from a register clocked with the accumulator.
module dmac_top
	import dmac_pkg::*;
#(
	parameter int OPW  = DMAC_OPW,
	parameter int ACCW = DMAC_ACCW
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// Configuration
	input  wire dmac_pkg::dmac_cfg_s    cfg,
	// Operands and per-cycle controls
	input  wire logic [OPW-1:0]         op_a,
	input  wire logic [OPW-1:0]         op_b,
	input  wire logic                   ser_in_a,
	input  wire logic                   ser_in_b,
	input  wire logic [ACCW-1:0]        init_val,
	input  wire dmac_pkg::dmac_ctl_s    ctl,
	// Results
	output logic      [2*OPW-1:0]       mult_out,
	output logic      [ACCW-1:0]        acc_out,
	output logic                        acc_ovf
);
	import dmac_pkg::*;

	localparam int PW = 2 * OPW;
	localparam int CW = $bits(dmac_ctl_s);

	// ----------------------------------------------------------------
	// Operand loading
	// ----------------------------------------------------------------
	// Serial loading shifts one bit per cycle into the operand holding
	// registers; parallel loading replaces the whole word. The mode may
	// change any cycle, so the shift chain always starts from held data.
	logic [OPW-1:0] a_hold_r, b_hold_r, a_hold_nxt, b_hold_nxt;

	assign a_hold_nxt = ctl.serial ? {a_hold_r[OPW-2:0], ser_in_a} : op_a;
	assign b_hold_nxt = ctl.serial ? {b_hold_r[OPW-2:0], ser_in_b} : op_b;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			a_hold_r <= '0;
			b_hold_r <= '0;
		end else begin
			a_hold_r <= a_hold_nxt;
			b_hold_r <= b_hold_nxt;
		end
	end

	wire [OPW-1:0] a_src = ctl.serial ? a_hold_nxt : op_a;
	wire [OPW-1:0] b_src = ctl.serial ? b_hold_nxt : op_b;

	// ----------------------------------------------------------------
	// Input and pipeline stages
	// ----------------------------------------------------------------
	// Controls ride through the same stages as the operands, so the sign
	// and add/subtract choice stay aligned with their data.
	logic [2*OPW+CW+ACCW-1:0] in_d, in_q;
	logic [PW+CW+ACCW-1:0]    pp_d, pp_q;
	logic [OPW-1:0]           a_s, b_s;
	dmac_ctl_s                ctl_s, ctl_p;
	logic [ACCW-1:0]          iv_s, iv_p;
	logic [PW-1:0]            prod, prod_p;

	assign in_d = {a_src, b_src, ctl, init_val};
	assign {a_s, b_s, ctl_s, iv_s} = in_q;

	dmac_stage #(.W(2*OPW+CW+ACCW)) u_in (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.bypass_n (cfg.in_reg_en),
		.d        (in_d),
		.q        (in_q)
	);

	// Extend by one bit with sign or zero so one signed multiplier serves
	// both modes.
	wire signed [OPW:0] a_x = {ctl_s.is_signed & a_s[OPW-1], a_s};
	wire signed [OPW:0] b_x = {ctl_s.is_signed & b_s[OPW-1], b_s};
	wire signed [2*OPW+1:0] prod_x = a_x * b_x;

	assign prod = prod_x[PW-1:0];
	assign pp_d = {prod, ctl_s, iv_s};
	assign {prod_p, ctl_p, iv_p} = pp_q;

	dmac_stage #(.W(PW+CW+ACCW)) u_pipe (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.bypass_n (cfg.pipe_reg_en),
		.d        (pp_d),
		.q        (pp_q)
	);

	// ----------------------------------------------------------------
	// Multiply element output
	// ----------------------------------------------------------------
	// The top level output is always a flop; when the output register is
	// bypassed it simply mirrors the product one edge later with no hold.
	logic [PW-1:0] mult_r, mult_hold_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mult_hold_r <= '0;
		end else begin
			mult_hold_r <= prod_p;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mult_r <= '0;
		end else begin
			mult_r <= cfg.mult_out_reg_en ? mult_hold_r : prod_p;
		end
	end

	assign mult_out = mult_r;

	// ----------------------------------------------------------------
	// Accumulator
	// ----------------------------------------------------------------
	logic [ACCW-1:0] acc_r, acc_nxt, base;
	logic            ovf_r, ovf_nxt;

	// Sign or zero extend the product to the accumulator width plus a guard bit.
	wire [ACCW:0] prod_e = {{(ACCW+1-PW){ctl_p.is_signed & prod_p[PW-1]}},
		prod_p};
	assign base = ctl_p.init ? iv_p : acc_r;
	wire [ACCW:0] base_e = {ctl_p.is_signed & base[ACCW-1], base};
	wire [ACCW:0] sum_e = ctl_p.subtract ? base_e - prod_e
		: base_e + prod_e;

	// Signed: guard and top bit disagree. Unsigned: carry or borrow out.
	assign acc_nxt = sum_e[ACCW-1:0];
	assign ovf_nxt = ctl_p.is_signed ? (sum_e[ACCW] ^ sum_e[ACCW-1])
		: sum_e[ACCW];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acc_r <= '0;
			ovf_r <= DMAC_RST_BIT;
		end else begin
			acc_r <= acc_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	assign acc_out = acc_r;
	assign acc_ovf = ovf_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// The registers clear on the edge at which reset is still seen high,
	// so each antecedent also asks for reset low in the sampled values;
	// otherwise a release in mid-run would be checked against stale totals.
	property p_acc_add;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en && !ctl.init
		 && !ctl.subtract && !ctl.is_signed && !ctl.serial)
		|=> acc_r == ACCW'($past(acc_r) + ACCW'($past(op_a) * $past(op_b)));
	endproperty
	a_acc_add: assert property (p_acc_add) else $error("acc add wrong");

	property p_acc_sub;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en && !ctl.init
		 && ctl.subtract && !ctl.is_signed && !ctl.serial)
		|=> acc_r == ACCW'($past(acc_r) - ACCW'($past(op_a) * $past(op_b)));
	endproperty
	a_acc_sub: assert property (p_acc_sub) else $error("acc sub wrong");

	property p_init;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en && ctl.init
		 && !ctl.subtract && !ctl.is_signed && !ctl.serial)
		|=> acc_r == ACCW'($past(init_val)
			+ ACCW'($past(op_a) * $past(op_b)));
	endproperty
	a_init: assert property (p_init) else $error("init not loaded");

	property p_mult_unsigned;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en
		 && !cfg.mult_out_reg_en && !ctl.is_signed && !ctl.serial)
		|=> mult_out == PW'($past(op_a) * $past(op_b));
	endproperty
	a_mult_unsigned: assert property (p_mult_unsigned) else $error("mult u");

	property p_mult_signed;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en
		 && !cfg.mult_out_reg_en && ctl.is_signed && !ctl.serial)
		|=> mult_out == PW'($signed($past(op_a)) * $signed($past(op_b)));
	endproperty
	a_mult_signed: assert property (p_mult_signed) else $error("mult s");

	sequence s_outreg_cfg;
		!sys_rst && !cfg.in_reg_en && !cfg.pipe_reg_en
		&& cfg.mult_out_reg_en;
	endsequence
	property p_mult_outreg;
		@(posedge mclk) disable iff (sys_rst)
		s_outreg_cfg ##0 (!ctl.is_signed && !ctl.serial) ##1 s_outreg_cfg
		|=> mult_out == PW'($past(op_a, 2) * $past(op_b, 2));
	endproperty
	a_mult_outreg: assert property (p_mult_outreg) else $error("out reg");

	property p_serial;
		@(posedge mclk) disable iff (sys_rst)
		!sys_rst && ctl.serial
		|=> a_hold_r == {$past(a_hold_r[OPW-2:0]), $past(ser_in_a)};
	endproperty
	a_serial: assert property (p_serial) else $error("serial shift");

	property p_ovf_reg;
		@(posedge mclk) disable iff (sys_rst)
		// A step that cannot carry must clear the flag: it is not sticky.
		(!sys_rst && !ctl_p.is_signed && !ctl_p.subtract && !ctl_p.init
		 && prod_p == '0) |=> !acc_ovf;
	endproperty
	a_ovf_reg: assert property (p_ovf_reg) else $error("ovf not reg");

	property p_ovf_uns;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !ctl_p.is_signed && !ctl_p.subtract && !ctl_p.init
		 && ({1'b0, acc_r} + {{(ACCW+1-PW){1'b0}}, prod_p}) > (ACCW+1)'({ACCW{1'b1}}))
		|=> acc_ovf;
	endproperty
	a_ovf_uns: assert property (p_ovf_uns) else $error("ovf missed");

	property p_ctl_align;
		@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && cfg.in_reg_en && !cfg.pipe_reg_en)
		|=> ctl_p == $past(ctl);
	endproperty
	a_ctl_align: assert property (p_ctl_align) else $error("ctl skew");
endmodule : dmac_top

// File: design/dmac_pkg.sv
/*
 * Shared constants and carrier types for the multiply / multiply-accumulate
 * slice. Assumes a single fabric clock and synchronous active-high reset.
 */
package dmac_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int DMAC_OPW = 18;
	localparam int DMAC_ACCW = 52;
	localparam logic DMAC_RST_BIT = 1'b0;

	// Per-cycle controls that travel with the operands.
	typedef struct packed {
		logic is_signed;
		logic subtract;
		logic init;
		logic serial;
	} dmac_ctl_s;

	// Static configuration: which optional registers are in the path.
	typedef struct packed {
		logic in_reg_en;
		logic pipe_reg_en;
		logic mult_out_reg_en;
	} dmac_cfg_s;

endpackage : dmac_pkg

// File: design/dmac_stage.sv
/*
 * One optional pipeline stage: a register that can be bypassed by a static
 * configuration bit. Assumes the select is quasi-static.
 */
module dmac_stage #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// Bypass select and data
	input  wire logic         bypass_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] q_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q_r <= '0;
		end else begin
			q_r <= d;
		end
	end

	assign q = bypass_n ? q_r : d;
endmodule : dmac_stage

// File: sim/dmac_fab.sv
/* Fabric logic model that drives operands and per-cycle controls.
 * Assumes the slice samples its inputs on the rising edge of mclk. */
module dmac_fab (
	// Clock
	input  wire logic                      mclk,
	// Operands and controls
	output logic [dmac_pkg::DMAC_OPW-1:0]  op_a,
	output logic [dmac_pkg::DMAC_OPW-1:0]  op_b,
	output logic                           ser_in_a,
	output logic                           ser_in_b,
	output logic [dmac_pkg::DMAC_ACCW-1:0] init_val,
	output dmac_pkg::dmac_ctl_s            ctl
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmac_pkg::*;
	// ------
	// Drive
	// ------
	// All fields move on one edge, so the controls qualify their operands.
	task automatic put(input logic [35:0] ab, input logic [3:0] c,
		input logic [51:0] v, input logic [1:0] s);
		@(posedge mclk);
		{op_a, op_b} <= ab;
		ctl <= c;
		init_val <= v;
		{ser_in_a, ser_in_b} <= s;
	endtask : put
	initial begin
		{op_a, op_b} = 36'h0;
		ctl = 4'h0;
		init_val = 52'h0;
		{ser_in_a, ser_in_b} = 2'h0;
	end
endmodule : dmac_fab

// File: sim/tb_dsp_multiply_accumulate.sv
/* Self-checking bench for the multiply and accumulate slice.
 * Assumes the fabric model sits on the operand side. */
module tb_dsp_multiply_accumulate;
	timeunit 1ns;
	timeprecision 1ps;
	import dmac_pkg::*;
	logic                  mclk;
	logic                  sys_rst;
	dmac_cfg_s             cfg;
	logic [DMAC_OPW-1:0]   op_a;
	logic [DMAC_OPW-1:0]   op_b;
	logic                  ser_in_a;
	logic                  ser_in_b;
	logic [DMAC_ACCW-1:0]  init_val;
	dmac_ctl_s             ctl;
	logic [2*DMAC_OPW-1:0] mult_out;
	logic [DMAC_ACCW-1:0]  acc_out;
	logic                  acc_ovf;
	int                    miscompares;
	int                    checks_done;
	int                    lat;
	logic [2:0]            cfgs [3] = '{3'h7, 3'h4, 3'h1};
	logic [17:0]           sa = 18'h00005;
	logic [17:0]           sb = 18'h00007;
	dmac_fab fab (.mclk(mclk), .op_a(op_a), .op_b(op_b),
		.ser_in_a(ser_in_a), .ser_in_b(ser_in_b),
		.init_val(init_val), .ctl(ctl));
	dmac_top dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg),
		.op_a(op_a), .op_b(op_b), .ser_in_a(ser_in_a),
		.ser_in_b(ser_in_b), .init_val(init_val), .ctl(ctl),
		.mult_out(mult_out), .acc_out(acc_out), .acc_ovf(acc_ovf));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ------
	// Tasks
	// ------
	task automatic check(input string nm, input logic [51:0] s, e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic res(input logic [35:0] m, input logic [51:0] a,
		input logic o);
		#1;
		check("mult", {16'h0000, mult_out}, {16'h0000, m});
		check("acc", acc_out, a);
		check("ovf", {51'h0, acc_ovf}, {51'h0, o});
	endtask : res
	// Every cycle is a request, so an operation is followed by zeros.
	task automatic op(input logic [35:0] ab, input logic [3:0] c,
		input logic [51:0] v);
		fab.put(ab, c, v, 2'h0);
		fab.put(36'h0, 4'h0, 52'h0, 2'h0);
	endtask : op
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	// ------
	// Sequence
	// ------
	initial begin
		cfg = 3'h0;
		sys_rst = 1'b1;
		miscompares = 0;
		checks_done = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		res(36'h0, 52'h0, 1'b0);
		op({18'h3, 18'h4}, 4'h0, 52'h0);
		res(36'hC, 52'hC, 1'b0);
		op({18'h3FFFE, 18'h3}, 4'h8, 52'h0);
		res(36'hFFFFFFFFA, 52'h6, 1'b0);
		op({18'h3FFFE, 18'h3}, 4'h0, 52'h0);
		res(36'hBFFFA, 52'hC0000, 1'b0);
		op({18'h5, 18'h5}, 4'hC, 52'h0);
		res(36'h19, 52'hBFFE7, 1'b0);
		op({18'h1, 18'h1}, 4'hA, 52'h7FFFFFFFFFFFF);
		res(36'h1, 52'h8000000000000, 1'b1);
		@(posedge mclk);
		res(36'h0, 52'h8000000000000, 1'b0);
		op({18'h1, 18'h1}, 4'h6, 52'h0);
		res(36'h1, 52'hFFFFFFFFFFFFF, 1'b1);
		op({18'h1, 18'h1}, 4'h0, 52'h0);
		res(36'h1, 52'h0, 1'b1);
		op({18'h2, 18'h3}, 4'h2, 52'h64);
		res(36'h6, 52'h6A, 1'b0);
		op({18'h2, 18'h2}, 4'h4, 52'h0);
		res(36'h4, 52'h66, 1'b0);
		// Partial sums of the shift are discarded by init on the last bit.
		for (int i = 17; i >= 0; i--) begin
			fab.put(36'h0, (i == 0) ? 4'h3 : 4'h1, 52'h0, {sa[i], sb[i]});
		end
		fab.put(36'h0, 4'h0, 52'h0, 2'h0);
		res(36'h23, 52'h23, 1'b0);
		op({18'h3, 18'h4}, 4'h0, 52'h0);
		res(36'hC, 52'h2F, 1'b0);
		foreach (cfgs[j]) begin
			@(posedge mclk);
			sys_rst <= 1'b1;
			cfg <= cfgs[j];
			@(posedge mclk);
			sys_rst <= 1'b0;
			lat = cfgs[j][2] + cfgs[j][1];
			op({18'h3, 18'h4}, 4'h0, 52'h0);
			for (int n = 0; n < 4; n++) begin
				#1;
				check("acc", acc_out, (n >= lat) ? 52'hC : 52'h0);
				// Zeros follow the operands, so the product stands one cycle.
				check("mult", {16'h0000, mult_out},
					(n == lat + cfgs[j][0]) ? 52'hC : 52'h0);
				@(posedge mclk);
			end
		end
		summarize();
	end
endmodule : tb_dsp_multiply_accumulate
